/* File: verilog/pprm_pkg.sv */
// Purpose: shared constants and types of the peripheral pin remap block
// Assumes: four-bit selection fields and one system clock
// Notes:   the lock and one-way bit positions are kept here; p_cc in pprm_chk also fixes the lock at bit 13
//
// Notes on behaviour
// - Each remappable pin's select field names the output driving it.
// - Output and input select registers are built of 4-bit fields.
// - Output fields reset to the null code 0, so no pin is driven.
// - While locked, select writes are accepted but change nothing.
// - Map lock is config control bit 13; one blocks select writes.
// - With one-way (config word three bit 29) set, lock can't clear.
// - With one-way set and lock set, only reset clears the lock.
// - An unprogrammed one-way bit counts as set: one write session.
package pprm_pkg;

  localparam int          SEL_W        = 4;
  localparam int          SEL_CODES    = 16;
  localparam logic [3:0]  SEL_NULL     = 4'h0;
  localparam logic [3:0]  SEL_RESET    = 4'h0;
  localparam int          LOCK_BIT     = 13;
  localparam int          ONE_WAY_BIT  = 29;
  localparam logic        LOCK_RESET   = 1'b0;
  localparam int          MAP_W        = 8;
  localparam logic [7:0]  MAP_NONE     = 8'hFF;
  // code k sits at bits [8k+7:8k]; code 0 and codes 9..15 are unassigned
  localparam logic [127:0] MAP_ROW_DEFAULT =
    128'hFFFF_FFFF_FFFF_FF07_0605_0403_0201_00FF;

  typedef enum logic [0:0] {
    PPRM_KIND_OUT = 1'b0,
    PPRM_KIND_IN  = 1'b1
  } pprm_kind_t;

endpackage

/* File: verilog/pprm_sel_if.sv */
// Purpose: carries select-field access and the stored fields between modules
// Assumes: one writer (control) and one store
// Notes:   read data is registered inside the store
`timescale 1ns/1ps
interface pprm_sel_if #(
  parameter int NUM_PINS   = 8,
  parameter int NUM_INPUTS = 8,
  parameter int IDX_W      = 4
);
  import pprm_pkg::*;
  logic                         we;
  pprm_kind_t                   kind;
  logic [IDX_W-1:0]             idx;
  logic [SEL_W-1:0]             wdata;
  logic [SEL_W-1:0]             rdata;
  logic [NUM_PINS*SEL_W-1:0]    out_sel;
  logic [NUM_INPUTS*SEL_W-1:0]  in_sel;

  modport store (input we, kind, idx, wdata, output rdata, out_sel, in_sel);
  modport ctl   (output we, kind, idx, wdata, input rdata, out_sel, in_sel);
endinterface

/* File: verilog/pprm_sel_store.sv */
// Purpose: holds the per-pin output select and per-input select fields
// Assumes: writes arrive already filtered by the lock
// Notes:   out-of-range index writes are dropped and read as zero
`timescale 1ns/1ps
module pprm_sel_store #(
  parameter int NUM_PINS   = 8,
  parameter int NUM_INPUTS = 8,
  parameter int IDX_W      = 4
) (
  input  wire logic   clk_i,   // system clock
  input  wire logic   srst_i,  // synchronous reset, active high
  pprm_sel_if.store   bus      // field access and stored fields
);
  import pprm_pkg::*;

  logic [SEL_W-1:0] out_reg [NUM_PINS];
  logic [SEL_W-1:0] in_reg  [NUM_INPUTS];
  logic [SEL_W-1:0] rdata_reg;

  // read index widths, so the array is never indexed with spare bits
  localparam int PIN_IDX_W = (NUM_PINS > 1) ? $clog2(NUM_PINS) : 1;
  localparam int IN_IDX_W  = (NUM_INPUTS > 1) ? $clog2(NUM_INPUTS) : 1;

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_out
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        out_reg[p] <= SEL_RESET;
      end else if (bus.we && bus.kind == PPRM_KIND_OUT &&
                   32'(bus.idx) == p) begin
        out_reg[p] <= bus.wdata;
      end
    end
    assign bus.out_sel[p*SEL_W +: SEL_W] = out_reg[p];
  end

  for (genvar j = 0; j < NUM_INPUTS; j++) begin : g_in
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        in_reg[j] <= SEL_RESET;
      end else if (bus.we && bus.kind == PPRM_KIND_IN &&
                   32'(bus.idx) == j) begin
        in_reg[j] <= bus.wdata;
      end
    end
    assign bus.in_sel[j*SEL_W +: SEL_W] = in_reg[j];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_reg <= SEL_RESET;
    end else if (bus.kind == PPRM_KIND_OUT && 32'(bus.idx) < NUM_PINS) begin
      rdata_reg <= out_reg[bus.idx[PIN_IDX_W-1:0]];
    end else if (bus.kind == PPRM_KIND_IN && 32'(bus.idx) < NUM_INPUTS) begin
      rdata_reg <= in_reg[bus.idx[IN_IDX_W-1:0]];
    end else begin
      rdata_reg <= 4'h0;
    end
  end
  assign bus.rdata = rdata_reg;

endmodule // pprm_sel_store

/* File: verilog/pprm_top.sv */
// Purpose: remappable output pin mux and input select with a map lock
// Assumes: unlock_done_i is high only after the system unlock sequence
// Notes:   all mux outputs are registered, so routing lags by one cycle;
//          a select write and a lock write in one cycle see the old lock;
//          the one-way option only changes while reset is held
`timescale 1ns/1ps
module pprm_top #(
  parameter int NUM_PINS   = 8,
  parameter int NUM_PERIPH = 8,
  parameter int NUM_INPUTS = 8,
  parameter int IDX_W      = 4,
  parameter logic [NUM_PINS*pprm_pkg::SEL_CODES*pprm_pkg::MAP_W-1:0]
    OUT_MAP = {NUM_PINS{pprm_pkg::MAP_ROW_DEFAULT}}
) (
  input  wire logic                    clk_i,          // system clock
  input  wire logic                    srst_i,         // sync reset, high
  input  wire logic [31:0]             device_config_word_three_i, // cfg
  input  wire logic                    config_programmed_i, // word valid
  input  wire logic                    unlock_done_i,  // unlock sequence ok
  input  wire logic                    config_control_wr_i,    // write
  input  wire logic [31:0]             config_control_wdata_i, // data
  output logic      [31:0]             config_control_o, // readback
  output logic                         pin_map_lock_o,   // lock state
  output logic                         lock_one_way_o,   // one-way active
  input  wire logic                    sel_wr_i,       // select write
  input  wire pprm_pkg::pprm_kind_t    sel_kind_i,     // output or input
  input  wire logic [IDX_W-1:0]        sel_idx_i,      // pin or input index
  input  wire logic [pprm_pkg::SEL_W-1:0] sel_wdata_i, // field value
  output logic      [pprm_pkg::SEL_W-1:0] sel_rdata_o, // field readback
  output logic                         sel_ack_o,      // write accepted
  output logic                         sel_blocked_o,  // write dropped
  input  wire logic [NUM_PERIPH-1:0]   periph_out_i,   // peripheral outs
  input  wire logic [NUM_PINS-1:0]     pin_i,          // pin levels
  output logic      [NUM_PINS-1:0]     pin_o,          // pin drive value
  output logic      [NUM_PINS-1:0]     pin_oe_o,       // pin drive enable
  output logic      [NUM_INPUTS-1:0]   periph_in_o     // peripheral ins
);
  import pprm_pkg::*;

  // index widths for the pin and peripheral vectors; the mux picks bits
  // from exactly these widths so no index is silently truncated
  localparam int PERIPH_IDX_W = (NUM_PERIPH > 1) ? $clog2(NUM_PERIPH) : 1;
  localparam int PIN_IDX_W    = (NUM_PINS > 1) ? $clog2(NUM_PINS) : 1;

  logic                   pin_map_lock_reg;
  logic                   pin_map_lock_next;
  logic                   lock_one_way_reg;
  logic                   lock_one_way_next;
  logic                   lock_wr_take;
  logic                   lock_clear_refused;
  logic [31:0]            config_control_reg;
  logic [31:0]            config_control_next;
  logic                   sel_ack_reg;
  logic                   sel_ack_next;
  logic                   sel_blocked_reg;
  logic                   sel_blocked_next;
  logic [NUM_PINS-1:0]    pin_reg;
  logic [NUM_PINS-1:0]    pin_oe_reg;
  logic [NUM_INPUTS-1:0]  periph_in_reg;

  // carrier between the lock gate here and the field store
  pprm_sel_if #(
    .NUM_PINS   (NUM_PINS),
    .NUM_INPUTS (NUM_INPUTS),
    .IDX_W      (IDX_W)
  ) sel_bus ();

  // locked writes never reach the store, so it needs no lock of its own
  pprm_sel_store #(
    .NUM_PINS   (NUM_PINS),
    .NUM_INPUTS (NUM_INPUTS),
    .IDX_W      (IDX_W)
  ) u_store (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .bus    (sel_bus.store)
  );

  // an erased config word counts as one-way set, the safe default
  always_comb begin
    lock_one_way_next = !config_programmed_i ||
                        device_config_word_three_i[ONE_WAY_BIT];
  end

  // latched only while reset is held, so a config word that moves later
  // cannot reopen a map that is locked one way
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lock_one_way_reg <= lock_one_way_next;
    end
  end

  // lock writes without a completed unlock are silently ignored; setting
  // is always allowed once unlocked, clearing may be refused
  always_comb begin
    lock_wr_take       = config_control_wr_i && unlock_done_i;
    lock_clear_refused = lock_one_way_reg && pin_map_lock_reg;
    pin_map_lock_next  = pin_map_lock_reg;
    if (lock_wr_take) begin
      if (config_control_wdata_i[LOCK_BIT]) begin
        pin_map_lock_next = 1'b1;
      end else if (!lock_clear_refused) begin
        pin_map_lock_next = 1'b0;
      end
    end
  end

  // only a reset reopens a map that was locked one way
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_map_lock_reg <= LOCK_RESET;
    end else begin
      pin_map_lock_reg <= pin_map_lock_next;
    end
  end

  // other config control bits belong elsewhere and read as zero here
  always_comb begin
    config_control_next           = '0;
    config_control_next[LOCK_BIT] = pin_map_lock_next;
  end

  // a registered copy keeps the readback in step with the lock flag
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      config_control_reg <= 32'(LOCK_RESET) << LOCK_BIT;
    end else begin
      config_control_reg <= config_control_next;
    end
  end
  assign config_control_o = config_control_reg;
  assign pin_map_lock_o   = pin_map_lock_reg;
  assign lock_one_way_o   = lock_one_way_reg;

  // the lock seen at the write edge decides, not a lock write beside it
  assign sel_bus.we    = sel_wr_i && !pin_map_lock_reg;
  assign sel_bus.kind  = sel_kind_i;
  assign sel_bus.idx   = sel_idx_i;
  assign sel_bus.wdata = sel_wdata_i;
  assign sel_rdata_o   = sel_bus.rdata;

  // every write is acknowledged so software sees no fault when locked;
  // the blocked flag is only a hint for tests and debug
  always_comb begin
    sel_ack_next     = sel_wr_i;
    sel_blocked_next = sel_wr_i && pin_map_lock_reg;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sel_ack_reg <= 1'b0;
    end else begin
      sel_ack_reg <= sel_ack_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sel_blocked_reg <= 1'b0;
    end else begin
      sel_blocked_reg <= sel_blocked_next;
    end
  end
  assign sel_ack_o     = sel_ack_reg;
  assign sel_blocked_o = sel_blocked_reg;

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic [SEL_W-1:0] code;
    logic [MAP_W-1:0] target;
    logic             assigned;
    logic             pin_next;
    logic             pin_oe_next;
    assign code   = sel_bus.out_sel[p*SEL_W +: SEL_W];
    assign target = OUT_MAP[(p*SEL_CODES + 32'(code))*MAP_W +: MAP_W];
    // null code, unassigned entry or out-of-range entry all leave the pin
    // undriven instead of picking an arbitrary peripheral
    assign assigned = code != SEL_NULL && target != MAP_NONE &&
                      32'(target) < NUM_PERIPH;

    // an undriven pin also shows zero so a released pin never echoes
    // the last peripheral level
    always_comb begin
      pin_oe_next = assigned;
      pin_next    = 1'b0;
      if (assigned) begin
        pin_next = periph_out_i[target[PERIPH_IDX_W-1:0]];
      end
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        pin_reg[p]    <= 1'b0;
        pin_oe_reg[p] <= 1'b0;
      end else begin
        pin_reg[p]    <= pin_next;
        pin_oe_reg[p] <= pin_oe_next;
      end
    end
  end
  assign pin_o    = pin_reg;
  assign pin_oe_o = pin_oe_reg;

  for (genvar j = 0; j < NUM_INPUTS; j++) begin : g_in
    logic [SEL_W-1:0] code;
    logic             periph_in_next;
    assign code = sel_bus.in_sel[j*SEL_W +: SEL_W];
    // codes past the last pin read as zero rather than wrapping around
    always_comb begin
      periph_in_next = 1'b0;
      if (32'(code) < NUM_PINS) begin
        periph_in_next = pin_i[code[PIN_IDX_W-1:0]];
      end
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        periph_in_reg[j] <= 1'b0;
      end else begin
        periph_in_reg[j] <= periph_in_next;
      end
    end
  end
  assign periph_in_o = periph_in_reg;

endmodule // pprm_top

/* File: tb/pprm_chk.sv */
// Purpose: port-level assertions of the pin remap top
// Assumes: one clock domain, synchronous reset srst_i
// Notes:   bound into pprm_top, watches control inputs and outputs
`timescale 1ns/1ps
module pprm_chk #(
  parameter int NUM_PINS = 8
) (
  input wire logic                clk_i,         // clock
  input wire logic                srst_i,        // reset
  input wire logic                unlock_done_i, // unlock level
  input wire logic                config_control_wr_i,    // cfg write
  input wire logic [31:0]         config_control_wdata_i, // cfg data
  input wire logic [31:0]         config_control_o, // cfg readback
  input wire logic                pin_map_lock_o,   // lock
  input wire logic                lock_one_way_o,   // one-way
  input wire logic                sel_wr_i,         // select write
  input wire logic                sel_ack_o,        // ack
  input wire logic                sel_blocked_o,    // dropped
  input wire logic [NUM_PINS-1:0] pin_oe_o          // drive enables
);
  import pprm_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_set;
    config_control_wr_i && unlock_done_i && config_control_wdata_i[LOCK_BIT];
  endsequence
  sequence s_wr_locked;
    sel_wr_i && pin_map_lock_o;
  endsequence
  property p_ack; sel_wr_i |=> sel_ack_o; endproperty
  property p_blk; s_wr_locked |=> sel_blocked_o; endproperty
  property p_free; sel_wr_i && !pin_map_lock_o |=> !sel_blocked_o;
  endproperty
  property p_set; s_set |=> pin_map_lock_o; endproperty
  property p_unl;
    !(config_control_wr_i && unlock_done_i) |=> $stable(pin_map_lock_o);
  endproperty
  property p_hold; pin_map_lock_o && lock_one_way_o |=> pin_map_lock_o;
  endproperty
  property p_cc; config_control_o == {18'h0, pin_map_lock_o, 13'h0};
  endproperty
  property p_rst; $fell(srst_i) |-> pin_oe_o == '0 && !pin_map_lock_o;
  endproperty
  property p_ow; $stable(lock_one_way_o); endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  a_blk: assert property (p_blk) else $error("drop unflagged");
  a_free: assert property (p_free) else $error("bad drop");
  a_set: assert property (p_set) else $error("lock not set");
  a_unl: assert property (p_unl) else $error("lock moved");
  a_hold: assert property (p_hold) else $error("lock cleared");
  a_cc: assert property (p_cc) else $error("cfg readback");
  a_rst: assert property (p_rst) else $error("reset state");
  a_ow: assert property (p_ow) else $error("one-way moved");
endmodule // pprm_chk
bind pprm_top pprm_chk #(.NUM_PINS(NUM_PINS)) u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .unlock_done_i(unlock_done_i),
  .config_control_wr_i(config_control_wr_i),
  .config_control_wdata_i(config_control_wdata_i),
  .config_control_o(config_control_o), .pin_map_lock_o(pin_map_lock_o),
  .lock_one_way_o(lock_one_way_o), .sel_wr_i(sel_wr_i),
  .sel_ack_o(sel_ack_o), .sel_blocked_o(sel_blocked_o),
  .pin_oe_o(pin_oe_o));

/* File: tb/pprm_far_model.sv */
// Purpose: peripheral outputs and pin levels beside the mux
// Assumes: changes at the falling edge, off the sampling edge
// Notes:   values move every cycle so stale routing shows up
`timescale 1ns/1ps
module pprm_far_model (
  input  wire logic       clk_i, // clock
  output logic      [7:0] per_o, // peripheral outputs
  output logic      [7:0] lvl_o  // pin levels
);
  initial begin
    per_o = 8'hA5;
    lvl_o = 8'h3C;
  end
  always @(negedge clk_i) begin
    per_o <= {per_o[6:0], per_o[7] ^ per_o[5] ^ per_o[4] ^ per_o[3]};
    lvl_o <= lvl_o + 8'h3B;
  end
endmodule // pprm_far_model

/* File: tb/test_output_pin_remap_with_lock.sv */
// Purpose: self-checking bench of the pin remap top
// Assumes: inputs change at the falling edge
// Notes:   a cycle model predicts every output each cycle
`timescale 1ns/1ps
module test_output_pin_remap_with_lock;
  import pprm_pkg::*;
  logic clk_i = 1'b0, srst_i = 1'b1, prog = 1'b0, unl = 1'b0, ccw = 1'b0;
  logic sw = 1'b0, go = 1'b0, lock, ow, ack, blk, m_lock, m_ow, e_ack, e_blk;
  logic [31:0] w3 = 32'h0, ccd = 32'h0, cco;
  pprm_kind_t kd = PPRM_KIND_OUT;
  logic [3:0] ix = 4'h0, wd = 4'h0, rd, e_rd, osel [8], isel [8];
  logic [7:0] per, lvl, po, poe, pin_in, e_po, e_poe, e_pin;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  pprm_far_model u_far (.clk_i(clk_i), .per_o(per), .lvl_o(lvl));
  pprm_top u_dut (
    .clk_i(clk_i), .srst_i(srst_i), .device_config_word_three_i(w3),
    .config_programmed_i(prog), .unlock_done_i(unl),
    .config_control_wr_i(ccw), .config_control_wdata_i(ccd),
    .config_control_o(cco), .pin_map_lock_o(lock), .lock_one_way_o(ow),
    .sel_wr_i(sw), .sel_kind_i(kd), .sel_idx_i(ix), .sel_wdata_i(wd),
    .sel_rdata_o(rd), .sel_ack_o(ack), .sel_blocked_o(blk),
    .periph_out_i(per), .pin_i(lvl), .pin_o(po), .pin_oe_o(poe),
    .periph_in_o(pin_in));
  always #25 clk_i = ~clk_i;
  function automatic logic [1:0] f_out(logic [3:0] c, logic [7:0] v);
    if (c == SEL_NULL || c > 4'h8) return 2'b00;
    return {1'b1, v[c - 4'h1]};
  endfunction
  always @(posedge clk_i) begin
    go = 1'b1;
    e_ack = sw && !srst_i;
    e_blk = e_ack && m_lock;
    e_rd = (srst_i || ix > 4'h7) ? 4'h0 : kd ? isel[ix[2:0]] : osel[ix[2:0]];
    for (int p = 0; p < 8; p++) begin
      {e_poe[p], e_po[p]} = srst_i ? 2'b00 : f_out(osel[p], per);
      e_pin[p] = !srst_i && isel[p] < 4'h8 && lvl[isel[p][2:0]];
    end
    if (srst_i) begin
      m_lock = LOCK_RESET;
      m_ow = !prog || w3[ONE_WAY_BIT];
      foreach (osel[p]) osel[p] = SEL_RESET;
      foreach (isel[p]) isel[p] = SEL_RESET;
    end else begin
      if (sw && !m_lock && ix < 4'h8 && kd) isel[ix[2:0]] = wd;
      if (sw && !m_lock && ix < 4'h8 && !kd) osel[ix[2:0]] = wd;
      if (ccw && unl) m_lock = ccd[LOCK_BIT] || (m_lock && m_ow);
    end
  end
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  always @(negedge clk_i) if (go) begin
    chk("pin_o", po, e_po);
    chk("pin_oe_o", poe, e_poe);
    chk("periph_in_o", pin_in, e_pin);
    chk("sel_rdata_o", rd, e_rd);
    chk("sel_ack_o", ack, e_ack);
    chk("sel_blocked_o", blk, e_blk);
    chk("pin_map_lock_o", lock, m_lock);
    chk("config_control_o", cco, 32'(m_lock) << LOCK_BIT);
    chk("lock_one_way_o", ow, m_ow);
  end
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic rst(logic pg, logic b29);
    srst_i = 1'b1;
    prog = pg;
    w3 = ($urandom() & ~(32'h1 << ONE_WAY_BIT)) | (32'(b29) << ONE_WAY_BIT);
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    srst_i = 1'b0;
  endtask
  task automatic cc(logic d, logic u);
    ccw = 1'b1;
    unl = u;
    ccd = ($urandom() & ~(32'h1 << LOCK_BIT)) | (32'(d) << LOCK_BIT);
    @(negedge clk_i);
    ccw = 1'b0;
  endtask
  task automatic run(int n);
    repeat (n) begin
      sw = 1'($urandom());
      kd = pprm_kind_t'($urandom_range(1));
      ix = 4'($urandom_range(9));
      wd = 4'($urandom());
      unl = 1'($urandom());
      @(negedge clk_i);
    end
    sw = 1'b0;
  endtask
  initial begin
    void'($urandom(50));
    rst(1'b0, 1'b0);
    run(40);
    cc(1'b1, 1'b0);
    run(5);
    cc(1'b1, 1'b1);
    run(30);
    cc(1'b0, 1'b1);
    run(10);
    $display("test 1 done");
    rst(1'b1, 1'b1);
    run(20);
    cc(1'b1, 1'b1);
    run(10);
    cc(1'b0, 1'b1);
    run(10);
    $display("test 2 done");
    rst(1'b1, 1'b0);
    cc(1'b1, 1'b1);
    run(10);
    cc(1'b0, 1'b1);
    run(30);
    $display("test 3 done");
    give_verdict();
  end
endmodule // test_output_pin_remap_with_lock
